//--- hdl/wdtc_pkg.sv
package wdtc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] WDTC_ADR_CONTROL = 8'h00;
  localparam logic [7:0] WDTC_ADR_STATUS = 8'h04;
  localparam logic [7:0] WDTC_ADR_MASK = 8'h08;
  localparam logic [7:0] WDTC_ADR_KICK = 8'h0c;
  localparam logic [7:0] WDTC_ADR_COUNT = 8'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int WDTC_SEL_LSB = 0;
  localparam int WDTC_SEL_W = 3;
  localparam int WDTC_ON_BIT = 3;
  localparam int WDTC_UNLOCK_BIT = 4;
  localparam logic [2:0] WDTC_RESERVED_VALUE = 3'h0;
  localparam logic [2:0] WDTC_SEL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Status and mask fields
  // ----------------------------------------------------------------
  localparam int WDTC_EVT_W = 2;
  localparam int WDTC_EVT_EXPIRED = 0;
  localparam int WDTC_EVT_REFUSED = 1;
  localparam logic [1:0] WDTC_EVT_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0] WDTC_UNLOCK_CYCLES = 3'h4;
  localparam int WDTC_CLK_PERIOD_NS = 20;
  localparam int WDTC_OSC_PERIOD_NS = 1000;
  localparam int WDTC_OSC_DIV = WDTC_OSC_PERIOD_NS / WDTC_CLK_PERIOD_NS;
  localparam int WDTC_TIMEOUT_BASE = 16384;
  localparam int WDTC_COUNT_W = 22;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDTC_LEVEL0,
    WDTC_LEVEL1,
    WDTC_LEVEL2
  } wdtc_level_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wdtc_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wdtc_wb_rsp_type;

  typedef struct packed {
    wdtc_level_type level;
    logic on;
    logic unlock;
    logic [2:0] unlock_cnt;
    logic [2:0] sel;
    logic kick_pending;
    logic run_on;
    logic [2:0] run_sel;
    logic [WDTC_COUNT_W-1:0] count;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic chip_reset;
    wdtc_wb_rsp_type rsp;
  } wdtc_state_type;

  // Expiry count for a timeout selection
  function automatic logic [WDTC_COUNT_W-1:0] wdtc_limit(
    input logic [WDTC_COUNT_W-1:0] base,
    input logic [2:0] sel
  );
    wdtc_limit = base << sel;
  endfunction : wdtc_limit

endpackage : wdtc_pkg

//--- hdl/wdtc_tick_div.sv
`timescale 1ns/1ps
module wdtc_tick_div
  import wdtc_pkg::*;
#(
  parameter int DIV = WDTC_OSC_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Oscillator-rate enable
  output logic tick
);

  logic [15:0] cnt;

  // Divider that stands in for the watchdog oscillator
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : wdtc_tick_div

//--- hdl/wdtc_top.sv
// Operation
// [R01] Control bits 7:5 always read back as zero.
// [R02] Unlock bit clears itself four system clocks after being written one.
// [R03] Writing watchdog_on one enables; zero disables, subject to locks.
// [R04] Zero to watchdog_on is taken only while unlock reads one.
// [R05] Software writes unlock and on together, then zero within four.
// [R06] In levels 1 and 2 timeout change needs unlock set.
// [R07] In level 2 the watchdog stays enabled whatever is written.
// [R08] Expiry count is 16384 shifted left by the timeout select.
// [R09] Software keeps interrupts off during the unlock-then-disable sequence.
// [R10] Count restarts on kick, while disabled, and on reset.
// [R11] Elapsed timeout without kick issues a chip reset.
// [R12] Two fuses fix the safety level and the start state.
// [R13] In level 2 watchdog_on always reads one; written value ignored.
// [R14] Configuration reaches the counter only at oscillator ticks.
// [R15] Locked timeout writes leave the selection unchanged.
`timescale 1ns/1ps
module wdtc_top
  import wdtc_pkg::*;
#(
  parameter int TIMEOUT_BASE = WDTC_TIMEOUT_BASE,
  parameter int OSC_DIV = WDTC_OSC_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fuses, active high when programmed
  input wire logic compat_fuse,
  input wire logic always_on_fuse,
  // Wishbone slave
  input wire wdtc_wb_req_type wb_req,
  output wdtc_wb_rsp_type wb_rsp,
  // Chip reset request and interrupt
  output logic chip_reset,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdtc_state_type state;
  wdtc_state_type next_state;
  logic tick;

  localparam logic [WDTC_COUNT_W-1:0] BASE = WDTC_COUNT_W'(TIMEOUT_BASE);

  // Oscillator-rate enable
  wdtc_tick_div #(
    .DIV(OSC_DIV)
  ) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Level from fuses
  function automatic wdtc_level_type level_of(input logic c, input logic a);
    if (a) begin
      level_of = WDTC_LEVEL2;
    end else if (c) begin
      level_of = WDTC_LEVEL0;
    end else begin
      level_of = WDTC_LEVEL1;
    end
  endfunction : level_of

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic access;
  logic wr;
  logic [7:0] wbyte;
  logic w_on;
  logic w_unlock;
  logic [2:0] w_sel;
  logic locked_sel;
  logic on_read;
  logic expire;
  logic [1:0] evt;

  // Bus decode and register behaviour
  always_comb begin
    next_state = state;
    evt = 2'h0;
    access = wb_req.cyc && wb_req.stb;
    wr = access && wb_req.we && state.rsp.ack;
    wbyte = wb_req.dat[7:0];
    w_on = wbyte[WDTC_ON_BIT];
    w_unlock = wbyte[WDTC_UNLOCK_BIT];
    w_sel = wbyte[WDTC_SEL_LSB +: WDTC_SEL_W];
    locked_sel = (state.level != WDTC_LEVEL0) && !state.unlock;
    on_read = (state.level == WDTC_LEVEL2) ? 1'b1 : state.on; // R13
    expire = 1'b0;

    // Unlock window countdown
    if (state.unlock) begin
      next_state.unlock_cnt = state.unlock_cnt - 3'h1;
      if (state.unlock_cnt == 3'h1) begin
        next_state.unlock = 1'b0; // R02
      end
    end

    // Control write
    if (wr && wb_req.adr == WDTC_ADR_CONTROL && wb_req.sel[0]) begin
      if (w_on) begin
        next_state.on = 1'b1; // R03
      end else if (state.unlock) begin
        next_state.on = 1'b0; // R04
      end else if (state.on) begin
        evt[WDTC_EVT_REFUSED] = 1'b1; // R04
      end
      if (state.level == WDTC_LEVEL2) begin
        next_state.on = 1'b1; // R07
      end
      if (!locked_sel) begin
        next_state.sel = w_sel; // R06
      end else if (w_sel != state.sel) begin
        evt[WDTC_EVT_REFUSED] = 1'b1; // R15
      end
      // Joint write of unlock and on opens the window
      if (w_unlock && w_on) begin
        next_state.unlock = 1'b1; // R05
        next_state.unlock_cnt = WDTC_UNLOCK_CYCLES; // R02
      end
    end

    // Kick, held until the next oscillator tick
    if (wr && wb_req.adr == WDTC_ADR_KICK) begin
      next_state.kick_pending = 1'b1;
    end

    // Mask write and write-one-to-clear status
    if (wr && wb_req.adr == WDTC_ADR_MASK && wb_req.sel[0]) begin
      next_state.mask = wbyte[WDTC_EVT_W-1:0];
    end
    if (wr && wb_req.adr == WDTC_ADR_STATUS && wb_req.sel[0]) begin
      next_state.status = state.status & ~wbyte[WDTC_EVT_W-1:0];
    end

    // Counter in the oscillator time base
    next_state.chip_reset = 1'b0;
    if (tick) begin
      next_state.run_on = state.on; // R14
      next_state.run_sel = state.sel; // R14
      if (!state.run_on || state.kick_pending) begin
        next_state.count = '0; // R10
      end else if (state.count ==
          wdtc_limit(BASE, state.run_sel) - WDTC_COUNT_W'(1)) begin // R08
        next_state.count = '0;
        expire = 1'b1; // R11
      end else begin
        next_state.count = state.count + WDTC_COUNT_W'(1);
      end
      next_state.kick_pending = wr && wb_req.adr == WDTC_ADR_KICK;
    end
    if (expire) begin
      next_state.chip_reset = 1'b1; // R11
      evt[WDTC_EVT_EXPIRED] = 1'b1;
    end

    // Events set after the clear so that a set wins
    next_state.status = next_state.status | evt;
    next_state.irq = |(next_state.status & next_state.mask);

    // Bus answer one cycle after the request, dropped the cycle after
    next_state.rsp.ack = access && !state.rsp.ack;
    next_state.rsp.dat = 32'h0000_0000;
    if (access && !state.rsp.ack) begin
      unique case (wb_req.adr)
        WDTC_ADR_CONTROL: begin
          next_state.rsp.dat[7:0] = {WDTC_RESERVED_VALUE, // R01
                                     state.unlock, on_read, state.sel};
        end
        WDTC_ADR_STATUS: begin
          next_state.rsp.dat[WDTC_EVT_W-1:0] = state.status;
        end
        WDTC_ADR_MASK: begin
          next_state.rsp.dat[WDTC_EVT_W-1:0] = state.mask;
        end
        WDTC_ADR_COUNT: begin
          next_state.rsp.dat[WDTC_COUNT_W-1:0] = state.count;
        end
        default: begin
          next_state.rsp.dat = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // State register with synchronous reset; fuses sampled here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
      state.level <= level_of(compat_fuse, always_on_fuse); // R12
      state.on <= always_on_fuse; // R12
      state.sel <= WDTC_SEL_RESET;
      state.status <= WDTC_EVT_RESET;
      state.mask <= WDTC_EVT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  assign wb_rsp = state.rsp;
  assign chip_reset = state.chip_reset;
  assign irq = state.irq;

endmodule : wdtc_top

//--- testbench/wdtc_chk.sv
`timescale 1ns/1ps
module wdtc_chk
  import wdtc_pkg::*;
#(
  parameter int TIMEOUT_BASE = WDTC_TIMEOUT_BASE,
  parameter int OSC_DIV = WDTC_OSC_DIV
) (
  // Clock, reset and fuses
  input wire logic clock,
  input wire logic rst_n,
  input wire logic compat_fuse,
  input wire logic always_on_fuse,
  // Bus and outputs
  input wire wdtc_wb_req_type wb_req,
  input wire wdtc_wb_rsp_type wb_rsp,
  input wire logic chip_reset,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Read answer at a given address
  sequence s_rd(a);
    wb_rsp.ack && !wb_req.we && wb_req.adr == a;
  endsequence
  a_ack_one_cycle: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held too long");
  a_ack_after_req: assert property
    (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack missing");
  a_ack_needs_req: assert property
    (wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb))
    else $error("ack without request");
  a_reserved_zero: assert property
    (s_rd(WDTC_ADR_CONTROL) |-> wb_rsp.dat[7:5] == WDTC_RESERVED_VALUE)
    else $error("reserved bits set");
  a_level2_on: assert property
    (always_on_fuse ##0 s_rd(WDTC_ADR_CONTROL) |-> wb_rsp.dat[WDTC_ON_BIT])
    else $error("enable reads zero");
  a_unmapped_zero: assert property
    (wb_rsp.ack && !wb_req.we && wb_req.adr > WDTC_ADR_COUNT
     |-> wb_rsp.dat == 32'h0)
    else $error("unmapped read not zero");
  a_count_width: assert property
    (s_rd(WDTC_ADR_COUNT) |-> wb_rsp.dat[31:WDTC_COUNT_W] == '0)
    else $error("count too wide");
  a_reset_pulse: assert property
    (chip_reset |=> !chip_reset [*4])
    else $error("reset pulse too long");
endmodule : wdtc_chk

bind wdtc_top wdtc_chk #(.TIMEOUT_BASE(TIMEOUT_BASE), .OSC_DIV(OSC_DIV))
  i_chk (.clock(clock), .rst_n(rst_n), .compat_fuse(compat_fuse),
  .always_on_fuse(always_on_fuse), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .chip_reset(chip_reset), .irq(irq));

//--- testbench/watchdog_timer_control_test.sv
`timescale 1ns/1ps
module watchdog_timer_control_test
  import wdtc_pkg::*;
();
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic compat_fuse = 1'b0;
  logic always_on_fuse = 1'b0;
  wdtc_wb_req_type wb_req = '0;
  wdtc_wb_rsp_type wb_rsp;
  logic chip_reset;
  logic irq;
  int fail_count = 0;
  int n_compared = 0;
  int pulses = 0;
  int n;
  int lim;
  logic [31:0] q;
  logic [2:0] s;
  logic lk;

  // Short counts keep the run brief
  wdtc_top #(.TIMEOUT_BASE(4), .OSC_DIV(2)) i_dut (.clock(clock),
    .rst_n(rst_n), .compat_fuse(compat_fuse),
    .always_on_fuse(always_on_fuse), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .chip_reset(chip_reset), .irq(irq));

  // Clock and pulse counter
  initial forever #10 clock = ~clock;
  always @(posedge clock) if (chip_reset === 1'b1) pulses++;

  // Selection is locked in levels 1 and 2
  function automatic logic locked(input logic c, input logic a);
    return !c || a;
  endfunction : locked

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle; read data lands in q
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock);
    wb_req <= {1'b1, 1'b1, w, a, 4'hf, 24'h0, d};
    do @(posedge clock); while (wb_rsp.ack !== 1'b1 && ++k < 50);
    // A missing answer counts as a mismatch
    if (wb_rsp.ack !== 1'b1) fail_count++;
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask : xfer

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard
  initial begin
    #1500000;
    fail_count++;
    print_verdict();
  end

  // Each safety level in turn
  initial begin
    q = $urandom(32'he030);
    for (int l = 0; l < 3; l++) begin
      rst_n <= 1'b0;
      compat_fuse <= (l == 0);
      always_on_fuse <= (l == 2);
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      lk = locked(l == 0, l == 2);
      // Early kicks keep the short timeout from running out before the loop
      xfer(1, WDTC_ADR_KICK, 8'h0);
      xfer(0, WDTC_ADR_CONTROL, 8'h0);
      check(q, {28'h0, l == 2, 3'h0});
      s = 3'($urandom) | 3'h1;
      xfer(1, WDTC_ADR_CONTROL, {5'h1, s});
      xfer(1, WDTC_ADR_KICK, 8'h0);
      xfer(1, WDTC_ADR_MASK, 8'h1);
      pulses = 0;
      repeat (10) xfer(1, WDTC_ADR_KICK, 8'h0);
      check(pulses, 0);
      xfer(0, WDTC_ADR_CONTROL, 8'h0);
      check(q, {28'h0, 1'b1, lk ? 3'h0 : s});
      lim = (4 << (lk ? 3'h0 : s)) * 2;
      n = 0;
      while (chip_reset !== 1'b1 && n < 3000) begin
        @(posedge clock);
        n++;
      end
      check((n > lim - 6) && (n < lim + 4), 1);
      repeat (3) @(posedge clock);
      check(irq, 1);
      xfer(0, WDTC_ADR_STATUS, 8'h0);
      check(q[0], 1);
      xfer(1, WDTC_ADR_MASK, 8'h0);
      repeat (3) @(posedge clock);
      check(irq, 0);
      // Locked disable, then a late one after the window
      xfer(1, WDTC_ADR_CONTROL, 8'h0);
      xfer(0, WDTC_ADR_STATUS, 8'h0);
      check(q[1], 1);
      xfer(1, WDTC_ADR_CONTROL, 8'h18);
      repeat (4) @(posedge clock);
      xfer(1, WDTC_ADR_CONTROL, 8'h0);
      xfer(0, WDTC_ADR_CONTROL, 8'h0);
      check(q[4:3], 2'b01);
      // Timed sequence inside the window
      xfer(1, WDTC_ADR_CONTROL, 8'h18);
      xfer(1, WDTC_ADR_CONTROL, {5'h0, s});
      xfer(0, WDTC_ADR_CONTROL, 8'h0);
      check(q, {28'h0, l == 2, s});
      // Write-one-to-clear of both status bits, then an idle count
      xfer(1, WDTC_ADR_STATUS, 8'h3);
      xfer(0, WDTC_ADR_STATUS, 8'h0);
      check(q[1], 0);
      if (l != 2) check(q[0], 0);
      xfer(0, WDTC_ADR_COUNT, 8'h0);
      if (l != 2) check(q, 0);
    end
    xfer(0, 8'h20, 8'h0);
    check(q, 32'h0);
    print_verdict();
  end
endmodule : watchdog_timer_control_test
